// file: bench/host_clk_model.sv
// Host side of the clock-hold line: keeps it asserted and releases it before slowing down.
// Assumes the device only drives the line through its enable, and high means asserted.
module host_clk_model (
    input  wire logic clk,         // Core clock.
    input  wire logic reset,       // Synchronous reset, high.
    input  wire logic slow_req,    // One-cycle pulse: host wants to slow the clock.
    input  wire logic clk_hold_oe, // Device drives the line while high.
    output logic      clk_hold_in  // Resolved line level seen by the device.
);
    timeunit 1ns;
    timeprecision 1ps;
    logic host_on_r;
    // The device driving the line counts as an assertion, as on a wired line.
    assign clk_hold_in = host_on_r | clk_hold_oe;
    always_ff @(posedge clk)
    begin
        if (reset)
            host_on_r <= 1'b1;
        else if (clk_hold_oe)
            host_on_r <= 1'b1;
        else if (slow_req)
            host_on_r <= 1'b0;
    end
endmodule

// file: bench/pci_config_space_sideband_tb.sv
// Self-checking bench for the configuration bank and its sideband pins.
// Assumes the parameter header and package are compiled first; LED dividers are shortened.
`include "cfg_space_params.svh"
module pci_config_space_sideband_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import cfg_space_pkg::*;
    localparam logic [31:0] TAG  = 32'h3C3C0002; // Arbitrary identification value.
    localparam logic [31:0] CARD = 32'h00A50040;
    logic clk = 0, reset = 1, soft_reset = 0, idsel = 1, ee_done = 0, wake_pattern = 0;
    logic power_opt_wol = 0, power_opt_wss = 0, clk_hold_en = 0, master_need = 0;
    logic csr_io_hit = 0, csr_mem_hit = 0, ref_clk_25 = 0, four_led = 0, slow_req = 0;
    logic [31:0] rd_data_par_in = '0, cfg_rdata, rd;
    logic [3:0]  cbe_par_in = '0;
    cfg_req_t    cfg_req = '0;
    eeprom_ids_t ee_ids = '0;
    phy_status_t phy_status = '0;
    logic cfg_ack, par_out, wake_n_oe, clk_hold_out, clk_hold_oe, bus_req_n, mac_only;
    logic csr_io_en, csr_mem_en, led_act, led_speed_low, led_speed_high, led_duplex, clk_hold_in;
    logic [7:0]  m;
    int          error_cnt = 0, comparisons = 0, cycles = 0, hi, tg;
    assign m = {led_act, led_speed_low, led_speed_high, led_duplex, wake_n_oe, clk_hold_oe,
                bus_req_n, mac_only};
    cfg_space_bank #(.PART_TAG(TAG), .CARD_INFO(CARD), .ACT_HALF(4), .COL_HALF(2))
        cfg_space_bank_i (
        .clk, .reset, .soft_reset, .cfg_req, .idsel, .rd_data_par_in, .cbe_par_in, .ee_ids,
        .ee_done, .wake_pattern, .power_opt_wol, .power_opt_wss, .clk_hold_en, .clk_hold_in,
        .master_need, .csr_io_hit, .csr_mem_hit, .ref_clk_25, .phy_status, .four_led, .cfg_ack,
        .cfg_rdata, .par_out, .wake_n_oe, .clk_hold_out, .clk_hold_oe, .bus_req_n, .mac_only,
        .csr_io_en, .csr_mem_en, .led_act, .led_speed_low, .led_speed_high, .led_duplex);
    host_clk_model host_clk_model_i (.clk, .reset, .slow_req, .clk_hold_oe, .clk_hold_in);
    always #2 clk = ~clk;
    always #20 ref_clk_25 = ~ref_clk_25;
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            error_cnt++;
            test_done();
        end
    end
    task test_done;
        $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e)
        begin
            $display("unexpected %s expected %h seen %h", n, e, g);
            error_cnt++;
        end
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // One access: taken at the next edge, answer read just after that same edge.
    task automatic cfg(input logic w, input logic [7:0] o, input logic [3:0] b,
                       input logic [31:0] d, input logic ea);
        wait_cyc(1);
        cfg_req = '{1'b1, w, o, b, d};
        wait_cyc(1);
        cfg_req.valid = 1'b0;
        rd = cfg_rdata;
        chk("ack", {31'h0, ea}, {31'h0, cfg_ack});
    endtask
    // One-shot inputs last exactly one edge, so the window starts with their cause.
    task automatic cnt(input int idx, input int n);
        logic last;
        hi = 0;
        tg = 0;
        last = m[idx];
        repeat (n)
        begin
            wait_cyc(1);
            wake_pattern = 1'b0;
            slow_req = 1'b0;
            ee_done = 1'b0;
            hi += (m[idx] === 1'b1);
            tg += (m[idx] !== last);
            last = m[idx];
        end
    endtask
    task automatic t_defaults;
        logic [7:0]  o[8] = '{8'h08, 8'h34, 8'hC0, 8'h80, 8'h28, 8'h18, 8'h38, 8'h00};
        logic [31:0] e[8] = '{`CLASS_REV_VALUE, 32'hC0, `PM_CAPS_VALUE, TAG, CARD, 0, 0, 0};
        for (int i = 0; i < 8; i++)
        begin
            cfg(1'b0, o[i], 4'hF, 32'h0, 1'b1);
            chk("reset value", e[i], rd);
            cfg(1'b1, o[i], 4'hF, 32'hFFFFFFFF, 1'b1);
            cfg(1'b0, o[i], 4'hF, 32'h0, 1'b1);
            chk("read only", e[i], rd);
        end
    endtask
    task t_scratch;
        cfg(1'b1, 8'h40, 4'h3, 32'hFFFFFFFF, 1'b1);
        cfg(1'b0, 8'h40, 4'hF, 32'h0, 1'b1);
        chk("scratch", 32'h000001FE, rd);
        cfg(1'b1, 8'h40, 4'h1, 32'h0, 1'b1);
        cfg(1'b0, 8'h40, 4'hF, 32'h0, 1'b1);
        chk("scratch byte", 32'h00000100, rd);
        soft_reset = 1'b1;
        wait_cyc(1);
        soft_reset = 1'b0;
        cfg(1'b0, 8'h40, 4'hF, 32'h0, 1'b1);
        chk("soft reset", 32'h00000100, rd);
        reset = 1'b1;
        wait_cyc(2);
        reset = 1'b0;
        wait_cyc(3);
        cfg(1'b0, 8'h40, 4'hF, 32'h0, 1'b1);
        chk("hard reset", 32'h0, rd);
        idsel = 1'b0;
        wait_cyc(3);
        cfg(1'b1, 8'h40, 4'hF, 32'hFFFFFFFF, 1'b0);
        idsel = 1'b1;
        wait_cyc(3);
        cfg(1'b0, 8'h40, 4'hF, 32'h0, 1'b1);
        chk("unselected write", 32'h0, rd);
    endtask
    task t_eeprom;
        ee_ids = '{16'h1234, 16'h5678, 16'h9ABC, 16'hDEF0, 8'h21, 8'h43};
        ee_done = 1'b1;
        cnt(0, 2);
        cfg(1'b1, 8'h00, 4'hF, 32'hFFFFFFFF, 1'b1);
        cfg(1'b0, 8'h00, 4'hF, 32'h0, 1'b1);
        chk("loaded ids", 32'h12345678, rd);
        cfg(1'b0, 8'h2C, 4'hF, 32'h0, 1'b1);
        chk("subsystem ids", 32'h9ABCDEF0, rd);
        cfg(1'b1, 8'h3C, 4'h1, 32'h0000005A, 1'b1);
        cfg(1'b0, 8'h3C, 4'hF, 32'h0, 1'b1);
        chk("timing", 32'h2143015A, rd);
    endtask
    task t_misc;
        cfg(1'b1, 8'hFC, 4'hF, 32'h4, 1'b1);
        wait_cyc(2);
        chk("mac only", 1, m[0]);
        cfg(1'b1, 8'hFC, 4'hF, 32'h5, 1'b1);
        wait_cyc(2);
        chk("mac only off", 0, m[0]);
        for (int i = 0; i < 4; i++)
        begin
            rd_data_par_in = 32'h80000001 << i;
            cbe_par_in = 4'(i);
            wait_cyc(2);
            chk("parity", ^{rd_data_par_in, cbe_par_in}, par_out);
        end
        cfg(1'b1, 8'h04, 4'hF, 32'h4, 1'b1);
        master_need = 1'b1;
        wait_cyc(3);
        chk("bus request", 0, m[1]);
        master_need = 1'b0;
        wait_cyc(3);
        chk("bus release", 1, m[1]);
        cfg(1'b1, 8'h04, 4'hF, 32'h3, 1'b1);
        {csr_io_hit, csr_mem_hit} = 2'h3;
        wait_cyc(2);
        chk("csr windows", 2'h3, {csr_io_en, csr_mem_en});
        {csr_io_hit, csr_mem_hit} = 2'h0;
        wait_cyc(1);
        chk("csr no hit", 2'h0, {csr_io_en, csr_mem_en});
    endtask
    task t_wake_hold;
        wake_pattern = 1'b1;
        cnt(3, 30);
        chk("wake disabled", 0, hi);
        power_opt_wol = 1'b1;
        wake_pattern = 1'b1;
        cnt(3, 30);
        chk("wake pulse", `WAKE_PULSE_CYCLES, hi);
        power_opt_wss = 1'b1;
        wake_pattern = 1'b1;
        cnt(3, 40);
        chk("wake held", 1, hi >= 36 && m[3] === 1'b1);
        power_opt_wol = 1'b0;
        cnt(3, 10);
        chk("wake cleared", 0, m[3]);
        slow_req = 1'b1;
        cnt(2, 20);
        chk("hold disabled", 0, hi);
        clk_hold_en = 1'b1;
        cnt(2, 20);
        chk("hold request", 1, hi > 0 && clk_hold_in === 1'b1);
    endtask
    task t_leds;
        phy_status = '{link_good: 1'b1, default: 1'b0};
        wait_cyc(5);
        cnt(7, 100);
        chk("link steady", 100, hi);
        phy_status = '{rx_act: 1'b1, default: 1'b0};
        wait_cyc(5);
        cnt(7, 400);
        chk("activity blink", 1, tg >= 9 && tg <= 11);
        phy_status = '{full_duplex: 1'b1, speed_100: 1'b1, default: 1'b0};
        wait_cyc(5);
        cnt(6, 50);
        chk("duplex steady", 50, hi);
        chk("3 led", 2'h2, {m[5], m[4]});
        four_led = 1'b1;
        phy_status = '{collision: 1'b1, speed_10: 1'b1, default: 1'b0};
        wait_cyc(5);
        cnt(4, 400);
        chk("collision blink", 1, tg >= 19 && tg <= 21);
        chk("4 led speed", 2'h2, {m[6], m[5]});
    endtask
    initial
    begin
        wait_cyc(6);
        reset = 1'b0;
        wait_cyc(3);
        t_defaults();
        t_scratch();
        t_eeprom();
        t_misc();
        t_wake_hold();
        t_leds();
        test_done();
    end
endmodule

// file: design/cfg_space_bank.sv
// Configuration register bank with wake, clock-hold, request, parity and LED sideband logic.
// Assumes the PCI target decoder presents accesses already qualified by a frame and that an
// EEPROM reader delivers the loaded identifiers with a done strobe after reset release.
// Operation
// - wake enable asserts wake output on pattern
// - style bit picks level or pulse wake
// - even parity over data and byte enables
// - reassert clock hold when host releases it
// - clock hold disabled means never driven
// - claim configuration accesses only with select
// - assert bus request when mastering needed
// - mode field 100b selects MAC-only operation
// - activity LED blinks 10 Hz, steady link in 3-LED
// - duplex LED steady, collision blinks 20 Hz
// - low speed LED steady at 10 Mb/s in 4-LED, duplex in 3-LED
// - high speed LED steady at 100 Mb/s
// - hardware reset defaults, software reset ignored
// - byte, word, dword access by enables
// - reload identifiers from EEPROM after reset
// - loaded ids register read-only device/vendor
// - card info register read-only, ignores writes
// - scratch bits 1 to 8 read/write
// - part tag hard-wired, read-only
// - power capability at C0, control at C4
// - CSRs reachable through I/O and memory
// - sample bus signals on rising clock
`include "cfg_space_params.svh"
module cfg_space_bank
    import cfg_space_pkg::*;
#(
    parameter logic [31:0] PART_TAG  = 32'h5A5A0001, // Arbitrary identification value.
    parameter logic [31:0] CARD_INFO = 32'h00000000, // Card information pointer value.
    parameter int          ACT_HALF  = `ACT_HALF_COUNT,
    parameter int          COL_HALF  = `COL_HALF_COUNT
)(
    input  wire logic        clk,            // Core clock.
    input  wire logic        reset,          // Hardware reset, synchronous, high.
    input  wire logic        soft_reset,     // Software reset; no effect here.
    input  wire cfg_req_t    cfg_req,        // Configuration access request.
    input  wire logic        idsel,          // Configuration select pin.
    input  wire logic [31:0] rd_data_par_in, // Read data to protect with parity.
    input  wire logic [3:0]  cbe_par_in,     // Byte enables of the read phase.
    input  wire eeprom_ids_t ee_ids,         // Identifiers from the EEPROM reader.
    input  wire logic        ee_done,        // EEPROM load finished.
    input  wire logic        wake_pattern,   // Wake-up frame seen, pulse.
    input  wire logic        power_opt_wol,  // Wake enable bit of power options.
    input  wire logic        power_opt_wss,  // Wake style bit of power options.
    input  wire logic        clk_hold_en,    // Clock-hold function enabled.
    input  wire logic        clk_hold_in,    // Clock hold pin level, high when asserted.
    input  wire logic        master_need,    // Engine needs bus ownership.
    input  wire logic        csr_io_hit,     // CSR access decoded in I/O space.
    input  wire logic        csr_mem_hit,    // CSR access decoded in memory space.
    input  wire logic        ref_clk_25,     // 25 MHz network reference, sampled.
    input  wire phy_status_t phy_status,     // Link status from the PHY side.
    input  wire logic        four_led,       // High selects the 4-LED scheme.
    output logic             cfg_ack,        // Access claimed and completed, pulse.
    output logic [31:0]      cfg_rdata,      // Read data.
    output logic             par_out,        // Even parity for the read phase.
    output logic             wake_n_oe,      // Wake pin pulls low while high.
    output logic             clk_hold_out,   // Clock hold drive level.
    output logic             clk_hold_oe,    // Clock hold driven while high.
    output logic             bus_req_n,      // Bus request, active low.
    output logic             mac_only,       // External MII selected.
    output logic             csr_io_en,      // CSR I/O window enabled.
    output logic             csr_mem_en,     // CSR memory window enabled.
    output logic             led_act,        // Activity / link LED.
    output logic             led_speed_low,  // 10 Mb/s LED, or duplex in 3-LED.
    output logic             led_speed_high, // 100 Mb/s LED.
    output logic             led_duplex      // Duplex/collision LED, 4-LED scheme.
);
    typedef struct packed {
        logic [31:0] loaded_ids;
        logic [15:0] command;
        logic [15:0] latency_cache;
        logic [31:0] io_base;
        logic [31:0] mem_base;
        logic [31:0] subsys_ids;
        logic [31:0] rom_base;
        logic [7:0]  int_line;
        logic [15:0] lat_gnt;
        logic [31:0] scratch;
        logic [15:0] pm_csr;
        logic [2:0]  mode_field;
        load_state_t load;
        logic        ack;
        logic [31:0] rdata;
        logic        par;
        logic        wake;
        logic [4:0]  wake_cnt;
        logic        hold_drive;
        logic        req_n;
        logic [1:0]  ref_sync;
        logic        ref_prev;
        logic [21:0] act_div;
        logic [21:0] col_div;
        logic        act_ph;
        logic        col_ph;
        logic [1:0]  hold_sync;
        logic [1:0]  sel_sync;
        logic [6:0]  led;
        logic        mac_sel;
        logic        io_en;
        logic        mem_en;
    } state_t;

    state_t s_r;
    state_t s_nxt;

    // Merges write data into a register through byte enables and a writable mask.
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] be, input logic [31:0] mask);
        logic [31:0] lanes;
        lanes = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        return (old & ~(lanes & mask)) | (wd & lanes & mask);
    endfunction

    logic        wr;
    logic        rd;
    logic [31:0] rv;
    logic        ref_rise;

    always_comb
    begin
        s_nxt = s_r;
        rv    = 32'h00000000;
        // The reference clock, clock hold and select pins pass two flops before anything reads them.
        s_nxt.ref_sync  = {s_r.ref_sync[0], ref_clk_25};
        s_nxt.hold_sync = {s_r.hold_sync[0], clk_hold_in};
        s_nxt.sel_sync  = {s_r.sel_sync[0], idsel};
        s_nxt.ref_prev  = s_r.ref_sync[1];
        ref_rise = s_r.ref_sync[1] & ~s_r.ref_prev;
        wr = cfg_req.valid & s_r.sel_sync[1] & cfg_req.write;
        rd = cfg_req.valid & s_r.sel_sync[1] & ~cfg_req.write;
        s_nxt.ack = wr | rd;

        // The identifiers arrive once after reset release; software reset does not restart it.
        case (s_r.load)
            LOAD_IDLE: s_nxt.load = LOAD_WAIT;
            LOAD_WAIT:
            begin
                if (ee_done)
                begin
                    s_nxt.loaded_ids = {ee_ids.device_id, ee_ids.vendor_id};
                    s_nxt.subsys_ids = {ee_ids.subsys_id, ee_ids.subsys_vendor_id};
                    s_nxt.lat_gnt    = {ee_ids.max_lat, ee_ids.min_gnt};
                    s_nxt.load       = LOAD_DONE;
                end
            end
            LOAD_DONE: s_nxt.load = LOAD_DONE;
            default:   s_nxt.load = LOAD_IDLE;
        endcase

        case (cfg_req.offset)
            `OFF_LOADED_IDS:     rv = s_r.loaded_ids;
            `OFF_STATUS_COMMAND: rv = {16'h0290, s_r.command};
            `OFF_CLASS_REVISION: rv = `CLASS_REV_VALUE;
            `OFF_LATENCY_CACHE:  rv = {16'h0000, s_r.latency_cache};
            `OFF_IO_BASE:        rv = s_r.io_base | 32'h00000001;
            `OFF_MEMORY_BASE:    rv = s_r.mem_base;
            `OFF_CARD_INFO:      rv = CARD_INFO;
            `OFF_SUBSYSTEM_IDS:  rv = s_r.subsys_ids;
            `OFF_EXP_ROM_BASE:   rv = s_r.rom_base;
            `OFF_CAP_POINTER:    rv = `CAP_PTR_VALUE;
            `OFF_INT_BUS_TIMING: rv = {s_r.lat_gnt, `INT_PIN_VALUE, s_r.int_line};
            `OFF_DRIVER_SCRATCH: rv = s_r.scratch;
            `OFF_PART_TAG:       rv = PART_TAG;
            `OFF_PM_CAPS:        rv = `PM_CAPS_VALUE;
            `OFF_PM_CTRL_STATUS: rv = {16'h0000, s_r.pm_csr};
            `OFF_MODE_FIELD:     rv = {29'h00000000, s_r.mode_field};
            default:             rv = 32'h00000000;
        endcase
        if (rd)
        begin
            s_nxt.rdata = rv;
        end

        if (wr)
        begin
            case (cfg_req.offset)
                `OFF_STATUS_COMMAND:
                    s_nxt.command = 16'(merge({16'h0000, s_r.command}, cfg_req.wdata,
                                              cfg_req.byte_en, `CMD_MASK));
                `OFF_LATENCY_CACHE:
                    s_nxt.latency_cache = 16'(merge({16'h0000, s_r.latency_cache},
                                                    cfg_req.wdata, cfg_req.byte_en,
                                                    32'h0000FFFF));
                `OFF_IO_BASE:
                    s_nxt.io_base = merge(s_r.io_base, cfg_req.wdata, cfg_req.byte_en,
                                          `IO_BASE_MASK);
                `OFF_MEMORY_BASE:
                    s_nxt.mem_base = merge(s_r.mem_base, cfg_req.wdata, cfg_req.byte_en,
                                           `MEM_BASE_MASK);
                `OFF_EXP_ROM_BASE:
                    s_nxt.rom_base = merge(s_r.rom_base, cfg_req.wdata, cfg_req.byte_en,
                                           `ROM_BASE_MASK);
                `OFF_INT_BUS_TIMING:
                    s_nxt.int_line = 8'(merge({24'h000000, s_r.int_line}, cfg_req.wdata,
                                              cfg_req.byte_en, 32'h000000FF));
                `OFF_DRIVER_SCRATCH:
                    s_nxt.scratch = merge(s_r.scratch, cfg_req.wdata, cfg_req.byte_en,
                                          `SCRATCH_MASK);
                `OFF_PM_CTRL_STATUS:
                    s_nxt.pm_csr = 16'(merge({16'h0000, s_r.pm_csr}, cfg_req.wdata,
                                             cfg_req.byte_en, `PM_CSR_MASK));
                `OFF_MODE_FIELD:
                    s_nxt.mode_field = 3'(merge({29'h00000000, s_r.mode_field},
                                                cfg_req.wdata, cfg_req.byte_en,
                                                32'h00000007));
                default: s_nxt.scratch = s_r.scratch;
            endcase
        end
        s_nxt.mac_sel = (s_nxt.mode_field == `MAC_ONLY_CODE);
        s_nxt.io_en   = s_nxt.command[0] & csr_io_hit;
        s_nxt.mem_en  = s_nxt.command[1] & csr_mem_hit;

        // Parity is computed over the data this device drives in a read phase.
        s_nxt.par = ^{rd_data_par_in, cbe_par_in};

        // Level style holds the pin low; the alternate style gives a fixed-width pulse.
        if (power_opt_wol & wake_pattern)
        begin
            s_nxt.wake     = 1'b1;
            s_nxt.wake_cnt = 5'(`WAKE_PULSE_CYCLES);
        end
        else if (!power_opt_wol)
        begin
            s_nxt.wake = 1'b0;
        end
        else if (!power_opt_wss && s_r.wake)
        begin
            if (s_r.wake_cnt <= 5'h01)
            begin
                s_nxt.wake = 1'b0;
            end
            s_nxt.wake_cnt = s_r.wake_cnt - 5'h01;
        end

        // Drive only when enabled and the host has let the line go.
        s_nxt.hold_drive = clk_hold_en & ~s_r.hold_sync[1];
        s_nxt.req_n = ~(master_need & s_r.command[2]);

        // Blink dividers advance only on reference edges, so rates follow the 25 MHz clock.
        if (ref_rise)
        begin
            if (s_r.act_div >= 22'(ACT_HALF - 1))
            begin
                s_nxt.act_div = 22'h000000;
                s_nxt.act_ph  = ~s_r.act_ph;
            end
            else
            begin
                s_nxt.act_div = s_r.act_div + 22'h000001;
            end
            if (s_r.col_div >= 22'(COL_HALF - 1))
            begin
                s_nxt.col_div = 22'h000000;
                s_nxt.col_ph  = ~s_r.col_ph;
            end
            else
            begin
                s_nxt.col_div = s_r.col_div + 22'h000001;
            end
        end
        // led bits: 0 act, 1 low, 2 high, 3 duplex.
        if ((phy_status.rx_act | phy_status.tx_act) & ~phy_status.collision)
            s_nxt.led[0] = s_r.act_ph;
        else
            s_nxt.led[0] = ~four_led & phy_status.link_good;
        s_nxt.led[3] = phy_status.full_duplex | (phy_status.collision & s_r.col_ph);
        s_nxt.led[1] = four_led ? phy_status.speed_10 : s_nxt.led[3];
        s_nxt.led[2] = phy_status.speed_100;
        if (!four_led)
        begin
            s_nxt.led[3] = 1'b0;
        end
        s_nxt.led[6:4] = 3'h0;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            s_r <= '0;
            s_r.req_n <= 1'b1;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign cfg_ack        = s_r.ack;
    assign cfg_rdata      = s_r.rdata;
    assign par_out        = s_r.par;
    assign wake_n_oe      = s_r.wake;
    assign clk_hold_out   = 1'b0;
    assign clk_hold_oe    = s_r.hold_drive;
    assign bus_req_n      = s_r.req_n;
    assign mac_only       = s_r.mac_sel;
    assign csr_io_en      = s_r.io_en;
    assign csr_mem_en     = s_r.mem_en;
    assign led_act        = s_r.led[0];
    assign led_speed_low  = s_r.led[1];
    assign led_speed_high = s_r.led[2];
    assign led_duplex     = s_r.led[3];

    property p_wake;
        @(posedge clk) disable iff (reset)
        (power_opt_wol && wake_pattern) |=> wake_n_oe;
    endproperty
    a_wake: assert property (p_wake) else $error("wake not raised");

    property p_wake_off;
        @(posedge clk) disable iff (reset)
        !power_opt_wol |=> !wake_n_oe;
    endproperty
    a_wake_off: assert property (p_wake_off) else $error("wake without enable");

    property p_hold;
        @(posedge clk) disable iff (reset)
        !clk_hold_en |=> !clk_hold_oe;
    endproperty
    a_hold: assert property (p_hold) else $error("hold driven while off");

    property p_ack_sel;
        @(posedge clk) disable iff (reset)
        cfg_ack |-> $past(s_r.sel_sync[1]);
    endproperty
    a_ack_sel: assert property (p_ack_sel) else $error("claimed without select");

    property p_req;
        @(posedge clk) disable iff (reset)
        !master_need |=> bus_req_n;
    endproperty
    a_req: assert property (p_req) else $error("request without need");

    property p_speed;
        @(posedge clk) disable iff (reset)
        phy_status.speed_100 |=> led_speed_high;
    endproperty
    a_speed: assert property (p_speed) else $error("speed led off");

    property p_tag;
        @(posedge clk) disable iff (reset)
        (rd && cfg_req.offset == `OFF_PART_TAG) |=> cfg_rdata == PART_TAG;
    endproperty
    a_tag: assert property (p_tag) else $error("part tag wrong");

    property p_par;
        @(posedge clk) disable iff (reset)
        1'b1 |=> par_out == ^{$past(rd_data_par_in), $past(cbe_par_in)};
    endproperty
    a_par: assert property (p_par) else $error("parity not even");

    sequence s_host_release;
        !clk_hold_in ##2 clk_hold_en;
    endsequence
    property p_hold_req;
        @(posedge clk) disable iff (reset)
        s_host_release |=> clk_hold_oe;
    endproperty
    a_hold_req: assert property (p_hold_req) else $error("hold not requested");

    sequence s_unselected_access;
        !idsel ##2 cfg_req.valid;
    endsequence
    property p_unsel;
        @(posedge clk) disable iff (reset)
        s_unselected_access |=> !cfg_ack;
    endproperty
    a_unsel: assert property (p_unsel) else $error("claimed while unselected");

    property p_mac;
        @(posedge clk) disable iff (reset)
        (wr && cfg_req.offset == `OFF_MODE_FIELD && cfg_req.byte_en[0]
            && cfg_req.wdata[2:0] == `MAC_ONLY_CODE) |=> mac_only;
    endproperty
    a_mac: assert property (p_mac) else $error("mac only not selected");
endmodule

// file: design/cfg_space_params.svh
// Constants for the configuration-space register bank: offsets, field positions, resets, timing.
// Assumes a 250 MHz core clock and a 25 MHz network reference sampled as a plain input.
`ifndef CFG_SPACE_PARAMS_SVH
`define CFG_SPACE_PARAMS_SVH
`define OFF_LOADED_IDS      8'h00
`define OFF_STATUS_COMMAND  8'h04
`define OFF_CLASS_REVISION  8'h08
`define OFF_LATENCY_CACHE   8'h0C
`define OFF_IO_BASE         8'h10
`define OFF_MEMORY_BASE     8'h14
`define OFF_CARD_INFO       8'h28
`define OFF_SUBSYSTEM_IDS   8'h2C
`define OFF_EXP_ROM_BASE    8'h30
`define OFF_CAP_POINTER     8'h34
`define OFF_INT_BUS_TIMING  8'h3C
`define OFF_DRIVER_SCRATCH  8'h40
`define OFF_PART_TAG        8'h80
`define OFF_PM_CAPS         8'hC0
`define OFF_PM_CTRL_STATUS  8'hC4
`define OFF_MODE_FIELD      8'hFC
`define MAC_ONLY_CODE       3'h4
`define CLASS_REV_VALUE     32'h02000011
`define CAP_PTR_VALUE       32'h000000C0
`define INT_PIN_VALUE       8'h01
`define PM_CAPS_VALUE       32'hFE800001
`define IO_BASE_MASK        32'hFFFFFF00
`define MEM_BASE_MASK       32'hFFFFFC00
`define ROM_BASE_MASK       32'hFFFC0001
`define SCRATCH_MASK        32'h000001FE
`define CMD_MASK            32'h00000147
`define PM_CSR_MASK         32'h00008103
`define WOL_BIT             18
`define WSS_BIT             17
`define REF_HZ              25000000
`define ACT_BLINK_HZ        10
`define COL_BLINK_HZ        20
`define ACT_HALF_COUNT      (`REF_HZ / (2 * `ACT_BLINK_HZ))
`define COL_HALF_COUNT      (`REF_HZ / (2 * `COL_BLINK_HZ))
`define WAKE_PULSE_NS       64
`define CLK_PERIOD_NS       4
`define WAKE_PULSE_CYCLES   ((`WAKE_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// file: design/cfg_space_pkg.sv
// Types shared by the configuration-space register bank.
// Assumes the parameter header is compiled alongside.
package cfg_space_pkg;
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [7:0]  offset;
        logic [3:0]  byte_en;
        logic [31:0] wdata;
    } cfg_req_t;
    typedef struct packed {
        logic        rx_act;
        logic        tx_act;
        logic        link_good;
        logic        full_duplex;
        logic        collision;
        logic        speed_100;
        logic        speed_10;
    } phy_status_t;
    typedef struct packed {
        logic [15:0] device_id;
        logic [15:0] vendor_id;
        logic [15:0] subsys_id;
        logic [15:0] subsys_vendor_id;
        logic [7:0]  max_lat;
        logic [7:0]  min_gnt;
    } eeprom_ids_t;
    typedef enum logic [1:0] {
        LOAD_IDLE,
        LOAD_WAIT,
        LOAD_DONE
    } load_state_t;
endpackage
